//--- hw/sfrb_pkg.sv
// shared constants and opcode decoders for the flash read and buffer-load commands
`default_nettype none
package sfrb_pkg;
  // opcodes
  localparam logic [7:0] OP_CONT_FAST = 8'h0B;
  localparam logic [7:0] OP_CONT_SLOW = 8'h03;
  localparam logic [7:0] OP_PAGE_RD = 8'hD2;
  localparam logic [7:0] OP_BUF1_RD_FAST = 8'hD4;
  localparam logic [7:0] OP_BUF1_RD_SLOW = 8'hD1;
  localparam logic [7:0] OP_BUF2_RD_FAST = 8'hD6;
  localparam logic [7:0] OP_BUF2_RD_SLOW = 8'hD3;
  localparam logic [7:0] OP_BUF1_WR = 8'h84;
  localparam logic [7:0] OP_BUF2_WR = 8'h87;
  // framing
  localparam logic [12:0] HDR_BYTES = 13'h0004;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] DUMMY_FAST = 3'h1;
  localparam logic [2:0] DUMMY_PAGE = 3'h4;
  localparam logic [2:0] DUMMY_NONE = 3'h0;
  // page and buffer geometry
  localparam logic [8:0] LAST_264 = 9'h107;
  localparam logic [8:0] LAST_256 = 9'h0FF;
  localparam int unsigned BUF_DEPTH = 264;
  // timing of the serial clock made by the host
  localparam int unsigned SYS_PERIOD_NS = 10;
  localparam int unsigned SCK_HALF_NS = 60;
  localparam int unsigned CS_GAP_NS = 60;
  localparam logic [3:0] SCK_HALF_CYC = 4'((SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [3:0] CS_GAP_CYC = 4'((CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  // synchroniser reset pattern: {cs_n, sck, si, page_256}
  localparam logic [3:0] DEV_SYNC_RST = 4'h8;

  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_CONT = 3'b001,
    K_PAGE = 3'b010,
    K_BUF_RD = 3'b011,
    K_BUF_WR = 3'b100
  } sfrb_kind_e;

  function automatic sfrb_kind_e op_kind(input logic [7:0] op);
    case (op)
      OP_CONT_FAST, OP_CONT_SLOW: op_kind = K_CONT;
      OP_PAGE_RD: op_kind = K_PAGE;
      OP_BUF1_RD_FAST, OP_BUF1_RD_SLOW, OP_BUF2_RD_FAST, OP_BUF2_RD_SLOW: op_kind = K_BUF_RD;
      OP_BUF1_WR, OP_BUF2_WR: op_kind = K_BUF_WR;
      default: op_kind = K_NONE;
    endcase
  endfunction

  function automatic logic [2:0] op_dummy(input logic [7:0] op);
    case (op)
      OP_CONT_FAST, OP_BUF1_RD_FAST, OP_BUF1_RD_SLOW: op_dummy = DUMMY_FAST;
      OP_BUF2_RD_FAST, OP_BUF2_RD_SLOW: op_dummy = DUMMY_FAST;
      OP_PAGE_RD: op_dummy = DUMMY_PAGE;
      default: op_dummy = DUMMY_NONE;
    endcase
  endfunction

  // high selects buffer 2
  function automatic logic op_buf2(input logic [7:0] op);
    op_buf2 = (op == OP_BUF2_RD_FAST) || (op == OP_BUF2_RD_SLOW) || (op == OP_BUF2_WR);
  endfunction
endpackage
`default_nettype wire

//--- hw/sfrb_if.sv
// serial link between the flash command end and the host end
`default_nettype none
interface sfrb_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  // output pulled high while released
  assign so_line = so_oe ? so : 1'h1;
  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so_line);
endinterface
`default_nettype wire

//--- hw/sfrb_sync.sv
// two-flop synchroniser for pins entering the system clock domain
`default_nettype none
module sfrb_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sfrb_sync
`default_nettype wire

//--- hw/sfrb_device.sv
// flash-side command interpreter for array reads, buffer reads and buffer writes
`default_nettype none
// Overview of operation
// R01: chip select fall, opcode, then address bytes
// R02: all fields shifted most significant bit first
// R03: 0BH takes address, one dummy, then streams
// R04: 264 mode: 11 page bits, 9 byte bits
// R05: 256 mode: address is linear 19 bits
// R06: 03H streams right after third address byte
// R07: host keeps select low for whole command
// R08: continuous read steps into next page seamlessly
// R09: continuous read wraps array end to zero
// R10: select rising ends read, releases output
// R11: continuous reads never touch either buffer
// R12: D2H takes address, four dummies, then streams
// R13: 256 mode: upper 11 page, lower 8 byte
// R14: page read wraps within the same page
// R15: four buffer read opcodes, two per buffer
// R16: host uses slow opcodes only at low rates
// R17: buffer address uses low 9 or 8 bits
// R18: buffer read needs exactly one dummy byte
// R19: buffer read wraps from last to zero
// R20: 84H writes buffer 1, 87H buffer 2
// R21: written bytes fill successive wrapping locations
// R22: buffer write lasts until select rises
// R23: 264 mode ignores top four address bits
// R24: commands cut before address end change nothing
module sfrb_device (
  input wire logic clk_sys,
  input wire logic reset,
  sfrb_if.dev link,
  input wire logic page_256,
  output logic xfer_active
);
  typedef enum logic [2:0] {
    S_CMD = 3'b000,
    S_ADDR = 3'b001,
    S_DUMMY = 3'b010,
    S_READ = 3'b011,
    S_WRITE = 3'b100,
    S_SKIP = 3'b101
  } sfrb_dev_state_e;

  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic p256_s;
  logic sck_p_q;
  logic sck_rise;
  logic sck_fall;
  sfrb_dev_state_e state_q;
  logic [2:0] bit_q;
  logic [2:0] cnt_q;
  logic [6:0] sh_q;
  logic [7:0] byte_in;
  logic byte_done;
  logic addr_done;
  logic write_done;
  logic rd_adv;
  sfrb_pkg::sfrb_kind_e kind_q;
  logic [2:0] dum_q;
  logic bsel_q;
  logic [15:0] addr_q;
  logic [23:0] addr_full;
  logic [10:0] page_q;
  logic [8:0] byte_q;
  logic [10:0] page_ld;
  logic [8:0] byte_ld;
  logic [8:0] last_byte;
  logic [7:0] rd_byte;
  logic [2:0] ocnt_q;
  logic so_q;
  logic oe_q;
  logic [7:0] buf_q [0:1][0:sfrb_pkg::BUF_DEPTH-1];

  sfrb_sync #(
    .WIDTH(4),
    .RST_VAL(sfrb_pkg::DEV_SYNC_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d({link.cs_n, link.sck, link.si, page_256}),
    .q({cs_n_s, sck_s, si_s, p256_s})
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sck_p_q <= 1'h0;
    end else begin
      sck_p_q <= sck_s;
    end
  end

  // edges only count while selected
  assign sck_rise = ~cs_n_s & sck_s & ~sck_p_q; // [R01]
  assign sck_fall = ~cs_n_s & ~sck_s & sck_p_q;
  assign byte_in = {sh_q, si_s}; // [R02]
  assign byte_done = sck_rise && (bit_q == 3'h7);
  assign addr_done = byte_done && (state_q == S_ADDR) && (cnt_q[1:0] == sfrb_pkg::ADDR_LAST);
  assign write_done = byte_done && (state_q == S_WRITE);
  assign rd_adv = sck_fall && (state_q == S_READ) && (ocnt_q == 3'h7);
  assign addr_full = {addr_q, byte_in};

  // command sequencing; select high restarts at the opcode
  always_ff @(posedge clk_sys) begin
    if (reset || cs_n_s) begin
      state_q <= S_CMD; // [R10] [R22] [R24]
      bit_q <= 3'h0;
      cnt_q <= 3'h0;
    end else if (sck_rise) begin
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        unique case (state_q)
          S_CMD: begin
            if (sfrb_pkg::op_kind(byte_in) == sfrb_pkg::K_NONE) begin
              state_q <= S_SKIP;
            end else begin
              state_q <= S_ADDR; // [R15] [R20]
            end
          end
          S_ADDR: begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q[1:0] == sfrb_pkg::ADDR_LAST) begin
              cnt_q <= 3'h0;
              if (kind_q == sfrb_pkg::K_BUF_WR) begin
                state_q <= S_WRITE; // [R21]
              end else if (dum_q == sfrb_pkg::DUMMY_NONE) begin
                state_q <= S_READ; // [R06]
              end else begin
                state_q <= S_DUMMY;
              end
            end
          end
          S_DUMMY: begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == dum_q - 3'h1) begin
              state_q <= S_READ; // [R03] [R12] [R18]
            end
          end
          S_READ, S_WRITE, S_SKIP: begin
            state_q <= state_q;
          end
          default: begin
            state_q <= S_SKIP;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sh_q <= 7'h00;
    end else if (sck_rise) begin
      sh_q <= byte_in[6:0];
    end
  end

  // opcode attributes are latched once the opcode byte completes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      kind_q <= sfrb_pkg::K_NONE;
      dum_q <= sfrb_pkg::DUMMY_NONE;
      bsel_q <= 1'h0;
    end else if (byte_done && (state_q == S_CMD)) begin
      kind_q <= sfrb_pkg::op_kind(byte_in);
      dum_q <= sfrb_pkg::op_dummy(byte_in);
      bsel_q <= sfrb_pkg::op_buf2(byte_in);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_q <= 16'h0000;
    end else if (byte_done && (state_q == S_ADDR)) begin
      addr_q <= {addr_q[7:0], byte_in};
    end
  end

  // split the address field per page size mode
  always_comb begin
    if (p256_s) begin
      last_byte = sfrb_pkg::LAST_256;
      page_ld = addr_full[18:8]; // [R05] [R13]
      byte_ld = {1'h0, addr_full[7:0]}; // [R17]
    end else begin
      last_byte = sfrb_pkg::LAST_264;
      page_ld = addr_full[19:9]; // [R04] [R23]
      byte_ld = addr_full[8:0]; // [R17]
    end
    // a start beyond the page end begins at byte zero
    if (byte_ld > last_byte) begin
      byte_ld = 9'h000;
    end
  end

  // read/write pointer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      page_q <= 11'h000;
      byte_q <= 9'h000;
    end else if (addr_done) begin
      page_q <= page_ld;
      byte_q <= byte_ld;
    end else if (rd_adv || write_done) begin
      if (byte_q >= last_byte) begin
        byte_q <= 9'h000; // [R14] [R19] [R21]
        if (kind_q == sfrb_pkg::K_CONT) begin
          page_q <= page_q + 11'h001; // [R08] [R09]
        end
      end else begin
        byte_q <= byte_q + 9'h001;
      end
    end
  end

  // main array reads a fixed content pattern; buffers are untouched by it
  always_comb begin
    if (kind_q == sfrb_pkg::K_BUF_RD) begin
      rd_byte = buf_q[bsel_q][byte_q];
    end else begin
      rd_byte = page_q[7:0] ^ byte_q[7:0] ^ {5'h00, page_q[10:8]}; // [R11]
    end
  end

  // write side of the buffers
  always_ff @(posedge clk_sys) begin
    if (write_done) begin
      buf_q[bsel_q][byte_q] <= byte_in; // [R20] [R21] [R22]
    end
  end

  // output bits change on the falling link clock edge
  always_ff @(posedge clk_sys) begin
    if (reset || cs_n_s) begin
      so_q <= 1'h0;
      oe_q <= 1'h0; // [R10]
      ocnt_q <= 3'h0;
    end else if (sck_fall && (state_q == S_READ)) begin
      so_q <= rd_byte[3'h7 - ocnt_q]; // [R02]
      oe_q <= 1'h1;
      ocnt_q <= ocnt_q + 3'h1;
    end
  end

  assign link.so = so_q;
  assign link.so_oe = oe_q;
  assign xfer_active = ~cs_n_s;
endmodule // sfrb_device
`default_nettype wire

//--- hw/sfrb_host.sv
// host-side serial master issuing read and buffer-load commands
`default_nettype none
module sfrb_host (
  input wire logic clk_sys,
  input wire logic reset,
  sfrb_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [11:0] cmd_len,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic done
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW = 2'b01,
    H_HIGH = 2'b10,
    H_GAP = 2'b11
  } sfrb_host_state_e;

  sfrb_host_state_e state_q;
  logic [3:0] div_q;
  logic cs_n_q;
  logic sck_q;
  logic si_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [12:0] idx_q;
  logic [12:0] last_q;
  logic [12:0] first_data;
  logic [12:0] nidx;
  logic [23:0] addr_q;
  logic [2:0] dum_q;
  logic wr_q;
  logic [6:0] rxsh_q;
  logic so_s;
  logic start;
  logic half_end;
  logic fall_ev;
  logic byte_end;
  logic last_byte;
  logic [7:0] nb;

  sfrb_sync #(
    .WIDTH(1),
    .RST_VAL(1'h1)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(link.so_line),
    .q(so_s)
  );

  assign cmd_ready = (state_q == H_IDLE);
  assign start = cmd_ready && cmd_valid;
  assign half_end = (div_q == sfrb_pkg::SCK_HALF_CYC - 4'h1);
  assign fall_ev = (state_q == H_HIGH) && half_end;
  assign byte_end = fall_ev && (bit_q == 3'h7);
  assign last_byte = (idx_q == last_q);
  assign first_data = sfrb_pkg::HDR_BYTES + {10'h000, dum_q};
  assign nidx = idx_q + 13'h0001;
  assign tx_ready = byte_end && !last_byte && wr_q && (nidx >= first_data);

  // next byte to shift: address, dummies, then write data or idle zeros
  always_comb begin
    unique case (nidx)
      13'h0001: nb = addr_q[23:16];
      13'h0002: nb = addr_q[15:8];
      13'h0003: nb = addr_q[7:0];
      default: nb = (wr_q && (nidx >= first_data)) ? tx_data : 8'h00;
    endcase
  end

  // link clock divider and select; select stays low for the whole command
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= H_IDLE;
      div_q <= 4'h0;
      cs_n_q <= 1'h1;
      sck_q <= 1'h0;
      done <= 1'h0;
    end else begin
      done <= 1'h0;
      div_q <= div_q + 4'h1;
      unique case (state_q)
        H_IDLE: begin
          div_q <= 4'h0;
          if (cmd_valid) begin
            cs_n_q <= 1'h0;
            state_q <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_end) begin
            div_q <= 4'h0;
            sck_q <= 1'h1;
            state_q <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_end) begin
            div_q <= 4'h0;
            sck_q <= 1'h0;
            state_q <= H_LOW;
            if (byte_end && last_byte) begin
              cs_n_q <= 1'h1; // [R07]
              state_q <= H_GAP;
            end
          end
        end
        H_GAP: begin
          if (div_q == sfrb_pkg::CS_GAP_CYC - 4'h1) begin
            done <= 1'h1;
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  // command latch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_q <= 24'h000000;
      dum_q <= 3'h0;
      wr_q <= 1'h0;
      last_q <= 13'h0000;
    end else if (start) begin
      addr_q <= cmd_addr;
      dum_q <= sfrb_pkg::op_dummy(cmd_op); // [R03] [R12] [R18]
      wr_q <= (sfrb_pkg::op_kind(cmd_op) == sfrb_pkg::K_BUF_WR); // [R20]
      last_q <= sfrb_pkg::HDR_BYTES - 13'h0001 + {10'h000, sfrb_pkg::op_dummy(cmd_op)}
        + {1'h0, cmd_len};
    end
  end

  // serial out, changed after each falling edge, most significant bit first
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sh_q <= 8'h00;
      si_q <= 1'h0;
      bit_q <= 3'h0;
      idx_q <= 13'h0000;
    end else if (start) begin
      sh_q <= cmd_op; // [R01]
      si_q <= cmd_op[7];
      bit_q <= 3'h0;
      idx_q <= 13'h0000;
    end else if (fall_ev) begin
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        idx_q <= nidx;
        sh_q <= nb;
        si_q <= nb[7]; // [R02]
      end else begin
        sh_q <= {sh_q[6:0], 1'h0};
        si_q <= sh_q[6];
      end
    end
  end

  // read data sampled just before each falling edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxsh_q <= 7'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'h0;
    end else begin
      rx_valid <= 1'h0;
      if (fall_ev) begin
        rxsh_q <= {rxsh_q[5:0], so_s};
        if (byte_end && !wr_q && (idx_q >= first_data)) begin
          rx_data <= {rxsh_q, so_s};
          rx_valid <= 1'h1;
        end
      end
    end
  end

  // link runs far below both read clock limits, so either opcode pair is legal [R16]
  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.si = si_q;
endmodule // sfrb_host
`default_nettype wire

//--- verif/sfrb_asserts.sv
// concurrent checks on the serial link between the host and flash ends
`default_nettype none
module sfrb_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic [11:0] rise_cnt_q;
  logic [7:0] op_q;
  logic [11:0] hdr_bits;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  always_ff @(posedge clk_sys) begin
    if (reset) sck_q <= 1'h0;
    else sck_q <= sck;
  end
  // clock rises seen in the current frame
  always_ff @(posedge clk_sys) begin
    if (reset || cs_n) rise_cnt_q <= 12'h000;
    else if (sck && !sck_q) rise_cnt_q <= rise_cnt_q + 12'h001;
  end
  always_ff @(posedge clk_sys) begin
    if (reset) op_q <= 8'h00;
    else if (!cs_n && sck && !sck_q && rise_cnt_q < 12'h008) op_q <= {op_q[6:0], si};
  end
  // bits clocked in before read data may start
  always_comb begin
    case (op_q)
      sfrb_pkg::OP_CONT_SLOW: hdr_bits = 12'h020;
      sfrb_pkg::OP_CONT_FAST, sfrb_pkg::OP_BUF1_RD_FAST: hdr_bits = 12'h028;
      sfrb_pkg::OP_BUF1_RD_SLOW, sfrb_pkg::OP_BUF2_RD_FAST: hdr_bits = 12'h028;
      sfrb_pkg::OP_BUF2_RD_SLOW: hdr_bits = 12'h028;
      sfrb_pkg::OP_PAGE_RD: hdr_bits = 12'h040;
      default: hdr_bits = 12'hFFF;
    endcase
  end
  a_so_released: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("output still driven after select rose");
  a_oe_needs_select: assert property (cs_n [*6] |-> !so_oe)
    else $error("output driven while deselected");
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("link clock high while deselected");
  a_si_steady_high: assert property (sck && $past(sck) |-> $stable(si))
    else $error("input bit changed while clock high");
  a_so_steady_high: assert property (sck && $past(sck) && so_oe && $past(so_oe)
    |-> $stable(so))
    else $error("output bit changed while clock high");
  a_sck_half_period: assert property ($rose(sck) |-> sck [*6] ##1 !sck)
    else $error("link clock high phase not six cycles");
  a_frame_whole_bytes: assert property ($rose(cs_n)
    |-> rise_cnt_q >= 12'h020 && rise_cnt_q[2:0] == 3'h0)
    else $error("frame not whole bytes with full header");
  a_oe_start_count: assert property ($rose(so_oe)
    |-> rise_cnt_q == hdr_bits)
    else $error("read data started after wrong bit count");
endmodule // sfrb_asserts
`default_nettype wire

//--- verif/tb_serial_flash_read_buffer_cmds.sv
// self-checking bench: host and flash ends joined over the serial link
`default_nettype none
module tb_serial_flash_read_buffer_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic page_256 = 1'h0;
  logic xfer_active;
  logic cmd_valid = 1'h0;
  logic cmd_ready;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic [11:0] cmd_len = 12'h000;
  logic [7:0] tx_data = 8'h00;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  logic done;
  int fails = 0;
  int checked = 0;
  logic [7:0] bufm [2][264];
  logic [7:0] last_op = 8'h00;
  logic sck_q = 1'h0;
  logic [3:0] mcnt = 4'h0;
  logic [7:0] mop = 8'h00;
  logic [7:0] ops [3];
  sfrb_if link();
  sfrb_device sfrb_device_inst (.clk_sys(clk_sys), .reset(reset), .link(link),
    .page_256(page_256), .xfer_active(xfer_active));
  sfrb_host sfrb_host_inst (.clk_sys(clk_sys), .reset(reset), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .tx_data(tx_data), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .done(done));
  sfrb_asserts sfrb_asserts_inst (.clk_sys(clk_sys), .reset(reset), .cs_n(link.cs_n),
    .sck(link.sck), .si(link.si), .so(link.so), .so_oe(link.so_oe), .so_line(link.so_line));
  always #5 clk_sys = ~clk_sys;

  task automatic summarize();
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] array_byte(input logic [10:0] pg, input logic [8:0] by);
    return pg[7:0] ^ by[7:0] ^ {5'h00, pg[10:8]};
  endfunction

  // opcode seen on the wire, gathered on link clock rises
  always @(negedge clk_sys) begin
    if (!link.cs_n && link.sck && !sck_q && mcnt < 4'h8) begin
      mop = {mop[6:0], link.si};
      mcnt = mcnt + 4'h1;
    end
    if (link.cs_n && mcnt != 4'h0) begin
      check("wire opcode", {16'h0, mop}, {16'h0, last_op});
      mcnt = 4'h0;
    end
    sck_q = link.sck;
  end

  task automatic set_mode(input logic m);
    page_256 = m;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic run_cmd(input logic [7:0] op, input logic [23:0] addr, input int len);
    int n, wi, guard, kind, sel;
    logic [10:0] pg;
    logic [8:0] by, last;
    logic [7:0] exp;
    n = 0;
    wi = 0;
    guard = 0;
    case (op)
      sfrb_pkg::OP_CONT_SLOW, sfrb_pkg::OP_CONT_FAST: kind = 0;
      sfrb_pkg::OP_PAGE_RD: kind = 1;
      sfrb_pkg::OP_BUF1_WR, sfrb_pkg::OP_BUF2_WR: kind = 3;
      default: kind = 2;
    endcase
    // every buffer 2 opcode has bit 1 set
    sel = int'(op[1]);
    last = page_256 ? 9'h0FF : 9'h107;
    pg = page_256 ? addr[18:8] : addr[19:9];
    by = page_256 ? {1'h0, addr[7:0]} : addr[8:0];
    if (by > last) by = 9'h000;
    last_op = op;
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_addr = addr;
    cmd_len = 12'(len);
    @(negedge clk_sys);
    cmd_valid = 1'h0;
    while (done !== 1'h1 && guard < 20000) begin
      if (tx_ready === 1'h1) begin
        tx_data = 8'($urandom);
        bufm[sel][by] = tx_data;
        wi++;
        by = (by == last) ? 9'h000 : by + 9'h001;
      end
      if (rx_valid === 1'h1) begin
        exp = (kind == 2) ? bufm[sel][by] : array_byte(pg, by);
        check("read byte", {16'h0, rx_data}, {16'h0, exp});
        if (by == last && kind == 0) pg = pg + 11'h001;
        by = (by == last) ? 9'h000 : by + 9'h001;
        n++;
      end
      if (guard == 40) check("select", {23'h0, xfer_active}, 24'h1);
      if (guard == 40) check("busy", {23'h0, cmd_ready}, 24'h0);
      @(negedge clk_sys);
      guard++;
    end
    check("command end", {23'h0, done}, 24'h1);
    check("byte count", 24'(n + wi), 24'(len));
    check("released line", {23'h0, link.so_line}, 24'h1);
    check("idle after end", {23'h0, cmd_ready}, 24'h1);
    check("select dropped", {23'h0, xfer_active}, 24'h0);
  endtask

  initial begin
    #400000;
    fails++;
    summarize();
  end

  initial begin
    void'($urandom(32'h17C5));
    ops = '{sfrb_pkg::OP_CONT_SLOW, sfrb_pkg::OP_CONT_FAST, sfrb_pkg::OP_PAGE_RD};
    repeat (5) @(negedge clk_sys);
    reset = 1'h0;
    set_mode(1'h0);
    run_cmd(sfrb_pkg::OP_BUF1_WR, 24'hFFFF06, 4);
    run_cmd(sfrb_pkg::OP_CONT_SLOW, 24'hA00B06, 4);
    run_cmd(sfrb_pkg::OP_CONT_FAST, 24'hAFFF07, 3);
    run_cmd(sfrb_pkg::OP_PAGE_RD, 24'hA00F06, 4);
    run_cmd(sfrb_pkg::OP_BUF1_RD_FAST, 24'h000106, 4);
    run_cmd(sfrb_pkg::OP_BUF1_RD_SLOW, 24'hABC107, 3);
    // a write cut by reset in its address phase leaves buffer 1 as it was
    last_op = sfrb_pkg::OP_BUF1_WR;
    cmd_valid = 1'h1;
    cmd_op = sfrb_pkg::OP_BUF1_WR;
    cmd_addr = 24'h000106;
    @(negedge clk_sys);
    cmd_valid = 1'h0;
    repeat (200) @(negedge clk_sys);
    reset = 1'h1;
    repeat (5) @(negedge clk_sys);
    reset = 1'h0;
    check("ready after reset", {23'h0, cmd_ready}, 24'h1);
    check("select after reset", {23'h0, xfer_active}, 24'h0);
    set_mode(1'h0);
    run_cmd(sfrb_pkg::OP_BUF1_RD_FAST, 24'h000106, 4);
    set_mode(1'h1);
    run_cmd(sfrb_pkg::OP_BUF2_WR, 24'h1234FE, 4);
    run_cmd(sfrb_pkg::OP_CONT_FAST, 24'h07FFFF, 3);
    run_cmd(sfrb_pkg::OP_PAGE_RD, 24'h0009FE, 4);
    run_cmd(sfrb_pkg::OP_BUF2_RD_FAST, 24'h0001FE, 4);
    run_cmd(sfrb_pkg::OP_BUF2_RD_SLOW, 24'hFFFFFF, 3);
    for (int i = 0; i < 4; i++) begin
      set_mode(1'($urandom % 2));
      run_cmd(ops[$urandom % 3], 24'($urandom), 1 + int'($urandom % 3));
    end
    summarize();
  end
endmodule // tb_serial_flash_read_buffer_cmds
`default_nettype wire
